/* File: pkg/rfs_defs.svh */
`ifndef RFS_DEFS_SVH
`define RFS_DEFS_SVH

// tracker control register
`define RFS_AUX_ADDR   6'h1a
`define RFS_AUX1_BIT   0
`define RFS_AUX2_BIT   1
`define RFS_AUX_RST    2'h0
`define RFS_ADDR_W     6
`define RFS_DATA_W     8

// sticky flag positions
`define RFS_NFLAG      4
`define RFS_FLG_IO     0
`define RFS_FLG_ANA    1
`define RFS_FLG_ADC    2
`define RFS_FLG_RET    3

// reset release delay after analog rail recovers
`define RFS_REL_DLY_MS 12
`define RFS_CLK_KHZ    50000
`define RFS_REL_CYC    (`RFS_REL_DLY_MS * `RFS_CLK_KHZ)
`define RFS_CNT_W      20

`endif

/* File: pkg/rfs_pkg.sv */
package rfs_pkg;

   // detector levels, one bit per comparator, high = condition present
   typedef struct packed {
      logic ref_c_fail;
      logic ref_b_fail;
      logic ref_a_fail;
      logic core_over;
      logic core_low;
      logic ana_over;
      logic ana_low;
      logic io_low_reset_level;
      logic io_low_warn_level;
      logic ret_low;
      logic adc_range;
      logic ana_range;
      logic io_range;
   } rfs_det_type;

   typedef enum logic [1:0] {
      RFS_ST_IDLE,
      RFS_ST_HOLD,
      RFS_ST_DELAY
   } rfs_state_type;

endpackage

/* File: verilog/rfs_supervisor.sv */
`timescale 1ns/100ps
`include "rfs_defs.svh"

module rfs_supervisor
#(
   parameter int unsigned REL_CYC = `RFS_REL_CYC
)
(
   input  wire logic                     mclk_i,
   input  wire logic                     rst_i,
   input  wire logic                     ce_i,
   input  wire rfs_pkg::rfs_det_type     det_i,
   input  wire logic                     ana_low_rst_en_i,
   input  wire logic [`RFS_NFLAG-1:0]    flag_clr_i,
   input  wire logic                     reg_wr_i,
   input  wire logic [`RFS_ADDR_W-1:0]   reg_addr_i,
   input  wire logic [`RFS_DATA_W-1:0]   reg_wdata_i,
   output logic [`RFS_DATA_W-1:0]        reg_rdata_o,
   output logic [`RFS_NFLAG-1:0]         flags_o,
   output logic                          irq_out_n_o,
   output logic                          early_warning_out_o,
   output logic                          system_reset_n_o,
   output logic                          core_switch_open_o,
   output logic                          retention_supply_switch_open_o,
   output logic                          conv_protect_o,
   output logic                          power_up_o,
   output logic                          rails_enable_o,
   output logic                          aux_rail1_on_o,
   output logic                          aux_rail2_on_o
);

   //***************************************************************
   // detector synchronisers
   //***************************************************************
   rfs_pkg::rfs_det_type       s1_q;
   rfs_pkg::rfs_det_type       s2_q;
   rfs_pkg::rfs_det_type       s3_q;
   logic [`RFS_NFLAG-1:0]      ev_lvl;
   logic [`RFS_NFLAG-1:0]      ev_old;
   logic [`RFS_NFLAG-1:0]      ev_rise;

   // s1_q feeds only s2_q; edges are taken between s2_q and s3_q
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else if (ce_i)
      begin
         s1_q <= det_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign ev_lvl[`RFS_FLG_IO]  = s2_q.io_range;
   assign ev_lvl[`RFS_FLG_ANA] = s2_q.ana_range;
   assign ev_lvl[`RFS_FLG_ADC] = s2_q.adc_range;
   assign ev_lvl[`RFS_FLG_RET] = s2_q.ret_low;
   assign ev_old[`RFS_FLG_IO]  = s3_q.io_range;
   assign ev_old[`RFS_FLG_ANA] = s3_q.ana_range;
   assign ev_old[`RFS_FLG_ADC] = s3_q.adc_range;
   assign ev_old[`RFS_FLG_RET] = s3_q.ret_low;

   //***************************************************************
   // sticky status flags
   //***************************************************************
   logic [`RFS_NFLAG-1:0]      flag_q;
   logic [`RFS_NFLAG-1:0]      flag_d;
   logic                       core_rst;

   assign core_rst = s2_q.core_low;

   // a crossing that lands on a clear cycle still sets its flag
   genvar gi;
   generate
      for (gi = 0; gi < `RFS_NFLAG; gi++)
      begin : g_flag
         assign ev_rise[gi] = ev_lvl[gi] & ~ev_old[gi];
         assign flag_d[gi]  = ev_rise[gi] |
                              (flag_q[gi] & ~flag_clr_i[gi] & ~core_rst);
      end
   endgenerate

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         flag_q <= '0;
      else if (ce_i)
         flag_q <= flag_d;
   end

   //***************************************************************
   // analog rail reset sequencer
   //***************************************************************
   rfs_pkg::rfs_state_type     st_q;
   rfs_pkg::rfs_state_type     st_d;
   logic [`RFS_CNT_W-1:0]      cnt_q;
   logic [`RFS_CNT_W-1:0]      cnt_d;
   logic                       cnt_end;

   assign cnt_end = (cnt_q == `RFS_CNT_W'(REL_CYC - 1));

   always_comb
   begin
      st_d  = st_q;
      cnt_d = cnt_q;
      unique case (st_q)
         rfs_pkg::RFS_ST_IDLE:
            if (ana_low_rst_en_i && s2_q.ana_low)
               st_d = rfs_pkg::RFS_ST_HOLD;
         rfs_pkg::RFS_ST_HOLD:
         begin
            cnt_d = '0;
            if (!s2_q.ana_low)
               st_d = rfs_pkg::RFS_ST_DELAY;
         end
         // a new dip restarts the full delay
         rfs_pkg::RFS_ST_DELAY:
            if (s2_q.ana_low)
               st_d = rfs_pkg::RFS_ST_HOLD;
            else if (cnt_end)
               st_d = rfs_pkg::RFS_ST_IDLE;
            else
               cnt_d = cnt_q + `RFS_CNT_W'(1);
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_q  <= rfs_pkg::RFS_ST_IDLE;
         cnt_q <= '0;
      end
      else if (ce_i)
      begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   //***************************************************************
   // tracker control register
   //***************************************************************
   logic [1:0]                 aux_q;
   logic                       aux_sel;

   assign aux_sel = (reg_addr_i == `RFS_AUX_ADDR);

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         aux_q <= `RFS_AUX_RST;
      else if (ce_i)
      begin
         if (core_rst)
            aux_q <= `RFS_AUX_RST;
         else if (reg_wr_i && aux_sel)
         begin
            aux_q[0] <= reg_wdata_i[`RFS_AUX1_BIT];
            aux_q[1] <= reg_wdata_i[`RFS_AUX2_BIT];
         end
      end
   end

   // unmapped addresses read zero
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         reg_rdata_o <= '0;
      else if (ce_i)
      begin
         reg_rdata_o <= '0;
         if (aux_sel)
         begin
            reg_rdata_o[`RFS_AUX1_BIT] <= aux_q[0];
            reg_rdata_o[`RFS_AUX2_BIT] <= aux_q[1];
         end
      end
   end

   //***************************************************************
   // registered outputs
   //***************************************************************
   logic                       pwr_ok;
   logic                       rails_ok;
   logic                       rst_req;

   assign pwr_ok   = ~(s2_q.ref_a_fail | s2_q.ref_b_fail);
   assign rails_ok = pwr_ok & ~s2_q.ref_c_fail;
   // reset is taken from next state so it drops on the same edge
   assign rst_req  = s2_q.io_low_reset_level | core_rst |
                     (st_d != rfs_pkg::RFS_ST_IDLE);

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         flags_o             <= '0;
         irq_out_n_o         <= 1'b1;
         early_warning_out_o <= 1'b0;
         system_reset_n_o    <= 1'b0;
      end
      else if (ce_i)
      begin
         flags_o             <= flag_d;
         irq_out_n_o         <= ~(|flag_d);
         early_warning_out_o <= s2_q.io_low_warn_level;
         system_reset_n_o    <= ~rst_req;
      end
   end

   // protective actions follow the detectors level for level
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         core_switch_open_o             <= 1'b0;
         retention_supply_switch_open_o <= 1'b0;
         conv_protect_o                 <= 1'b0;
      end
      else if (ce_i)
      begin
         core_switch_open_o             <= s2_q.core_over;
         retention_supply_switch_open_o <= s2_q.core_over;
         conv_protect_o                 <= s2_q.ana_over;
      end
   end

   // a tracker only turns on when the rails are allowed to power up
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         power_up_o     <= 1'b0;
         rails_enable_o <= 1'b0;
         aux_rail1_on_o <= 1'b0;
         aux_rail2_on_o <= 1'b0;
      end
      else if (ce_i)
      begin
         power_up_o     <= pwr_ok;
         rails_enable_o <= rails_ok;
         aux_rail1_on_o <= aux_q[0] & rails_ok;
         aux_rail2_on_o <= aux_q[1] & rails_ok;
      end
   end

   //***************************************************************
   // assertions
   //***************************************************************
   property p_flag_set;
      @(posedge mclk_i) disable iff (rst_i)
      ce_i && (|ev_rise) |=> (flags_o & $past(ev_rise)) == $past(ev_rise);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("event did not set its flag");
   property p_irq;
      @(posedge mclk_i) disable iff (rst_i)
      irq_out_n_o == ~(|flags_o);
   endproperty
   a_irq: assert property (p_irq) else $error("irq level disagrees with flags");
   property p_warn;
      @(posedge mclk_i) disable iff (rst_i)
      ce_i ##1 ce_i ##1 ce_i |=> early_warning_out_o == $past(det_i.io_low_warn_level, 3);
   endproperty
   a_warn: assert property (p_warn) else $error("warning does not follow detector");
   property p_io_rst;
      @(posedge mclk_i) disable iff (rst_i)
      ce_i && s2_q.io_low_reset_level |=> !system_reset_n_o;
   endproperty
   a_io_rst: assert property (p_io_rst) else $error("io low did not reset");
   property p_core_rst;
      @(posedge mclk_i) disable iff (rst_i)
      ce_i && core_rst |=> !system_reset_n_o && aux_q == `RFS_AUX_RST &&
         flag_q == $past(ev_rise);
   endproperty
   a_core_rst: assert property (p_core_rst) else $error("core low did not reset");
   property p_switch;
      @(posedge mclk_i) disable iff (rst_i)
      ce_i |=> core_switch_open_o == $past(s2_q.core_over) &&
               retention_supply_switch_open_o == core_switch_open_o;
   endproperty
   a_switch: assert property (p_switch) else $error("switch does not follow core over");
   property p_protect;
      @(posedge mclk_i) disable iff (rst_i)
      ce_i && s2_q.ana_over |=> conv_protect_o;
   endproperty
   a_protect: assert property (p_protect) else $error("no converter protect");
   property p_no_en;
      @(posedge mclk_i) disable iff (rst_i)
      ce_i && st_q == rfs_pkg::RFS_ST_IDLE && !ana_low_rst_en_i |=>
         st_q == rfs_pkg::RFS_ST_IDLE;
   endproperty
   a_no_en: assert property (p_no_en) else $error("analog low reset while disabled");
   property p_release;
      @(posedge mclk_i) disable iff (rst_i)
      ce_i && st_q == rfs_pkg::RFS_ST_DELAY && !s2_q.ana_low && cnt_end |=>
         st_q == rfs_pkg::RFS_ST_IDLE;
   endproperty
   a_release: assert property (p_release) else $error("delay end did not release");
   property p_refs;
      @(posedge mclk_i) disable iff (rst_i)
      ce_i && (s2_q.ref_a_fail || s2_q.ref_b_fail || s2_q.ref_c_fail) |=>
         !rails_enable_o && !aux_rail1_on_o && !aux_rail2_on_o &&
         power_up_o == !($past(s2_q.ref_a_fail) || $past(s2_q.ref_b_fail));
   endproperty
   a_refs: assert property (p_refs) else $error("rail on with failed reference");
   property p_upper_zero;
      @(posedge mclk_i) disable iff (rst_i)
      reg_rdata_o[`RFS_DATA_W-1:2] == 6'h00;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");
   property p_wr;
      @(posedge mclk_i) disable iff (rst_i)
      ce_i && reg_wr_i && aux_sel && !core_rst |=> aux_q == $past(reg_wdata_i[1:0]);
   endproperty
   a_wr: assert property (p_wr) else $error("tracker write lost");

endmodule

/* File: dv/rfs_host_model.sv */
`timescale 1ns/100ps
// ****************************************************
// host side: counts interrupt and reset requests
// ****************************************************
module rfs_host_model
(
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        irq_out_n_i,
   input  wire logic        system_reset_n_i,
   output logic [7:0]       irq_count_o,
   output logic [7:0]       reset_count_o
);
   logic irq_n_q;
   logic rst_n_q;

   // only falling edges count, a held level is one request
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         irq_n_q       <= 1'b1;
         rst_n_q       <= 1'b0;
         irq_count_o   <= 8'h00;
         reset_count_o <= 8'h00;
      end
      else
      begin
         irq_n_q <= irq_out_n_i;
         rst_n_q <= system_reset_n_i;
         if (irq_n_q && !irq_out_n_i)
            irq_count_o <= irq_count_o + 8'h01;
         if (rst_n_q && !system_reset_n_i)
            reset_count_o <= reset_count_o + 8'h01;
      end
   end
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/100ps
`include "rfs_defs.svh"
module testbench;
   logic mclk_i = 0, rst_i = 1, ce_i = 1, ana_low_rst_en_i = 0, reg_wr_i = 0;
   rfs_pkg::rfs_det_type det_i = '0;
   logic [3:0] flag_clr_i = 4'h0, flags_o;
   logic [5:0] reg_addr_i = 6'h00;
   logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, irq_cnt, rst_cnt, rd_v;
   logic irq_n, warn, rst_n, core_sw, ret_sw, conv, pwr, rails, aux1, aux2;
   int fail_count = 0;
   int checks = 0;
   int bits[4] = '{4, 5, 9, 7};
   logic [7:0] lv_exp[4] = '{8'h10, 8'h08, 8'h06, 8'h01};

   rfs_supervisor #(.REL_CYC(8)) i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
      .det_i(det_i), .ana_low_rst_en_i(ana_low_rst_en_i), .flag_clr_i(flag_clr_i),
      .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .flags_o(flags_o), .irq_out_n_o(irq_n),
      .early_warning_out_o(warn), .system_reset_n_o(rst_n), .core_switch_open_o(core_sw),
      .retention_supply_switch_open_o(ret_sw), .conv_protect_o(conv), .power_up_o(pwr),
      .rails_enable_o(rails), .aux_rail1_on_o(aux1), .aux_rail2_on_o(aux2));

   rfs_host_model i_host (.mclk_i(mclk_i), .rst_i(rst_i), .irq_out_n_i(irq_n),
      .system_reset_n_i(rst_n), .irq_count_o(irq_cnt), .reset_count_o(rst_cnt));

   // ****************************************************
   // helpers
   // ****************************************************
   initial
   begin
      forever #10 mclk_i = ~mclk_i;
   end

   task automatic step(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      reg_wr_i    = 1'b1;
      reg_addr_i  = a;
      reg_wdata_i = d;
      step(1);
      reg_wr_i = 1'b0;
      // one idle edge keeps back-to-back writes from toggling the strobe twice at once
      step(1);
   endtask

   task automatic rd(input logic [5:0] a);
      reg_addr_i = a;
      step(2);
      rd_v = reg_rdata_o;
   endtask

   function automatic logic [7:0] lvl();
      return {3'h0, warn, ~rst_n, core_sw, ret_sw, conv};
   endfunction

   // ****************************************************
   // scenarios
   // ****************************************************
   task automatic t_reset;
      chk("reset_n", 8'(rst_n), 8'h01);
      chk("flags", 8'(flags_o), 8'h00);
      rd(`RFS_AUX_ADDR);
      chk("aux_reg", rd_v, 8'h00);
   endtask

   task automatic t_reg;
      wr(`RFS_AUX_ADDR, 8'hff);
      rd(`RFS_AUX_ADDR);
      chk("aux_reg", rd_v, 8'h03);
      chk("aux_on", 8'({aux2, aux1}), 8'h03);
      wr(`RFS_AUX_ADDR, 8'h02);
      wr(6'h1b, 8'h01);
      rd(`RFS_AUX_ADDR);
      chk("aux_reg", rd_v, 8'h02);
      rd(6'h1b);
      chk("unmapped", rd_v, 8'h00);
      wr(`RFS_AUX_ADDR, 8'h03);
   endtask

   task automatic t_flags;
      for (int i = 0; i < 4; i++)
      begin
         det_i = rfs_pkg::rfs_det_type'(13'h1 << i);
         step(4);
         chk("flags", 8'(flags_o), 8'(4'h1 << i));
         chk("irq_n", 8'(irq_n), 8'h00);
         flag_clr_i = 4'h1 << i;
         step(1);
         flag_clr_i = 4'h0;
         step(4);
         chk("flags_held", 8'(flags_o), 8'h00);
         chk("irq_n", 8'(irq_n), 8'h01);
         det_i = '0;
         step(3);
      end
      chk("irq_count", irq_cnt, 8'h04);
   endtask

   task automatic t_levels;
      for (int i = 0; i < 4; i++)
      begin
         det_i = rfs_pkg::rfs_det_type'(13'h1 << bits[i]);
         step(4);
         chk("levels", lvl(), lv_exp[i]);
         det_i = '0;
         step(4);
         chk("levels_idle", lvl(), 8'h00);
      end
      chk("reset_count", rst_cnt, 8'h01);
   endtask

   task automatic t_refs;
      det_i.ref_a_fail = 1'b1;
      step(4);
      chk("pwr_a", 8'({pwr, rails, aux2, aux1}), 8'h00);
      det_i = '0;
      det_i.ref_c_fail = 1'b1;
      step(4);
      chk("pwr_c", 8'({pwr, rails, aux2, aux1}), 8'h08);
      det_i = '0;
      step(4);
      chk("pwr_ok", 8'({pwr, rails, aux2, aux1}), 8'h0f);
   endtask

   task automatic t_ana_rst;
      ana_low_rst_en_i = 1'b1;
      det_i.ana_low    = 1'b1;
      step(4);
      chk("ana_rst", 8'(rst_n), 8'h00);
      det_i = '0;
      // release lands 2 sync edges + 1 state edge + REL_CYC (8) edges after the fall
      step(10);
      chk("ana_hold", 8'(rst_n), 8'h00);
      step(1);
      chk("ana_rel", 8'(rst_n), 8'h01);
      ana_low_rst_en_i = 1'b0;
      det_i.ana_low    = 1'b1;
      step(4);
      chk("ana_off", 8'(rst_n), 8'h01);
      det_i = '0;
      step(4);
   endtask

   task automatic t_core_low;
      det_i.core_low = 1'b1;
      step(4);
      chk("core_rst", 8'(rst_n), 8'h00);
      det_i = '0;
      step(4);
      chk("core_rel", 8'(rst_n), 8'h01);
      rd(`RFS_AUX_ADDR);
      chk("aux_init", rd_v, 8'h00);
   endtask

   task automatic t_ce;
      ce_i = 1'b0;
      det_i.io_range = 1'b1;
      step(4);
      chk("ce_frozen", 8'(flags_o), 8'h00);
      ce_i = 1'b1;
      step(4);
      chk("ce_run", 8'(flags_o), 8'h01);
      det_i = '0;
      step(4);
   endtask

   // ****************************************************
   // run
   // ****************************************************
   task automatic print_verdict;
      if (fail_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (4) @(posedge mclk_i);
      #1 rst_i = 1'b0;
      step(1);
      t_reset();
      t_reg();
      t_flags();
      t_levels();
      t_refs();
      t_ana_rst();
      t_core_low();
      t_ce();
      print_verdict();
   end

   // the whole sequence needs well under 300 cycles
   initial
   begin
      #50000;
      fail_count++;
      print_verdict();
   end
endmodule
